/* dim_map.v */
`include "dpb_consts.vh"
// maps brightness (0..100) to dimmer wiper step by mode
module dim_map (
	input wire i_clock,
	input wire i_rst,
	input wire i_voltage_mode,
	input wire [6:0] i_level,
	output reg [6:0] o_step
);
	always @(posedge i_clock)
	begin
		if (i_rst)
			o_step <= 7'h00;
		else if (i_voltage_mode)
			o_step <= `DIM_STEPS - i_level;
		else
			o_step <= i_level;
	end
endmodule

/* display_power_backlight_ctrl.v */
`include "dpb_consts.vh"
// Notes on behaviour
// - panel supply on first; pixel and sync drive only after supply settles
// - on power-down, stop pixel and sync drive before removing supply
// - read four panel id bits at power-up to identify panel maker
// - sample memory strap at power-up: fitted is EDO, absent is FPM
// - configure panel control behaviour from detected id and memory straps
// - one backlight enable output; polarity strap selects active level
// - dim backlight to half after ten minutes without key press
// - key press while dimmed returns backlight to full brightness
// - brightness set as dimmer position with exactly one hundred steps
// - voltage mode: minimum output full brightness, maximum zero brightness
// - resistance mode: minimum zero brightness, maximum full; direct mapping
// - both mode straps fitted gives voltage mode; both removed resistance
module display_power_backlight_ctrl #(
	parameter [39:0] IDLE_LIMIT = `IDLE_CYCLES,
	parameter [15:0] SEQ_GAP = `SEQ_GAP_CYCLES
) (
	input wire i_clock,
	input wire i_rst,
	input wire [3:0] i_panel_id,
	input wire i_dram_type_strap,
	input wire i_backlight_polarity_strap,
	input wire i_dimmer_mode_strap_a,
	input wire i_dimmer_mode_strap_b,
	input wire i_key_press,
	// axi4-lite slave
	input wire [7:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [7:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready,
	// panel side
	output reg o_panel_supply_en,
	output reg o_panel_drive_en,
	output reg o_backlight_enable,
	output reg [6:0] o_dimmer_step,
	output reg o_dram_edo,
	output reg [3:0] o_panel_cfg
);
	localparam S_OFF = 4'b0001;
	localparam S_SUPPLY = 4'b0010;
	localparam S_ON = 4'b0100;
	localparam S_DRAIN = 4'b1000;

	reg [3:0] state_reg;
	reg [15:0] gap_reg;
	reg strapped_reg;
	reg [3:0] panel_id_reg;
	reg edo_reg;
	reg voltage_mode_reg;
	reg bl_polarity_reg;
	reg ctrl_pwr_reg;
	reg ctrl_bl_reg;
	reg [6:0] full_level_reg;
	reg [39:0] limit_reg;
	reg [6:0] level_reg;
	reg dimmed_reg;
	reg have_aw_reg;
	reg have_w_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg timer_restart_reg;
	wire expired;
	wire [6:0] step;

	function [31:0] merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer k;
		begin
			merge = old_val;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[k*8 +: 8] = new_val[k*8 +: 8];
		end
	endfunction

	function [6:0] clamp_level;
		input [31:0] v;
		begin
			// whole word compared so large writes clamp instead of wrapping
			clamp_level = (v > `DIM_STEPS) ? `DIM_STEPS : v[6:0];
		end
	endfunction

	idle_timer #(
		.WIDTH(40),
		.LIMIT(IDLE_LIMIT)
	) u_idle (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_key(i_key_press | timer_restart_reg),
		.i_limit(limit_reg),
		.o_expired(expired)
	);

	dim_map u_map (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_voltage_mode(voltage_mode_reg),
		.i_level(level_reg),
		.o_step(step)
	);

	// straps caught once, first clocked cycle after reset release
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			strapped_reg <= 1'b0;
			panel_id_reg <= 4'h0;
			edo_reg <= 1'b0;
			voltage_mode_reg <= 1'b0;
			bl_polarity_reg <= 1'b0;
		end
		else if (!strapped_reg)
		begin
			strapped_reg <= 1'b1;
			panel_id_reg <= i_panel_id;
			edo_reg <= i_dram_type_strap;
			// mixed strap setting is treated as resistance mode
			voltage_mode_reg <= i_dimmer_mode_strap_a & i_dimmer_mode_strap_b;
			bl_polarity_reg <= i_backlight_polarity_strap;
		end
	end

	// power sequencing
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg <= S_OFF;
			gap_reg <= 16'h0000;
			o_panel_supply_en <= 1'b0;
			o_panel_drive_en <= 1'b0;
		end
		else
		begin
			case (state_reg)
				S_OFF:
				begin
					if (ctrl_pwr_reg && strapped_reg)
					begin
						o_panel_supply_en <= 1'b1;
						gap_reg <= 16'h0000;
						state_reg <= S_SUPPLY;
					end
				end
				S_SUPPLY:
				begin
					if (!ctrl_pwr_reg)
					begin
						o_panel_supply_en <= 1'b0;
						state_reg <= S_OFF;
					end
					else if (gap_reg >= SEQ_GAP - 16'h0001)
					begin
						o_panel_drive_en <= 1'b1;
						state_reg <= S_ON;
					end
					else
						gap_reg <= gap_reg + 16'h0001;
				end
				S_ON:
				begin
					if (!ctrl_pwr_reg)
					begin
						o_panel_drive_en <= 1'b0;
						gap_reg <= 16'h0000;
						state_reg <= S_DRAIN;
					end
				end
				S_DRAIN:
				begin
					if (gap_reg >= SEQ_GAP - 16'h0001)
					begin
						o_panel_supply_en <= 1'b0;
						state_reg <= S_OFF;
					end
					else
						gap_reg <= gap_reg + 16'h0001;
				end
				default:
				begin
					state_reg <= S_OFF;
					o_panel_supply_en <= 1'b0;
					o_panel_drive_en <= 1'b0;
				end
			endcase
		end
	end

	// brightness and backlight
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			level_reg <= `DIM_FULL;
			dimmed_reg <= 1'b0;
			o_backlight_enable <= 1'b0;
			o_dimmer_step <= 7'h00;
			o_dram_edo <= 1'b0;
			o_panel_cfg <= 4'h0;
		end
		else
		begin
			if (i_key_press)
			begin
				dimmed_reg <= 1'b0;
				level_reg <= full_level_reg;
			end
			else if (expired)
			begin
				dimmed_reg <= 1'b1;
				level_reg <= `DIM_HALF;
			end
			else if (!dimmed_reg)
				level_reg <= full_level_reg;
			// polarity unknown until straps are caught; hold the reset level 0, which is off for active-high polarity and on for active-low
			if (strapped_reg)
				o_backlight_enable <= (ctrl_bl_reg & o_panel_drive_en) ^ ~bl_polarity_reg;
			o_dimmer_step <= step;
			o_dram_edo <= edo_reg;
			o_panel_cfg <= panel_id_reg;
		end
	end

	// axi4-lite write
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= `AXI_OKAY;
			have_aw_reg <= 1'b0;
			have_w_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			ctrl_pwr_reg <= 1'b0;
			ctrl_bl_reg <= 1'b0;
			full_level_reg <= `DIM_FULL;
			limit_reg <= IDLE_LIMIT;
			timer_restart_reg <= 1'b0;
		end
		else
		begin
			timer_restart_reg <= 1'b0;
			o_s_axi_awready <= !have_aw_reg && !o_s_axi_awready && !o_s_axi_bvalid;
			o_s_axi_wready <= !have_w_reg && !o_s_axi_wready && !o_s_axi_bvalid;
			if (o_s_axi_awready && i_s_axi_awvalid)
			begin
				have_aw_reg <= 1'b1;
				aw_addr_reg <= i_s_axi_awaddr;
				o_s_axi_awready <= 1'b0;
			end
			if (o_s_axi_wready && i_s_axi_wvalid)
			begin
				have_w_reg <= 1'b1;
				wdata_reg <= i_s_axi_wdata;
				wstrb_reg <= i_s_axi_wstrb;
				o_s_axi_wready <= 1'b0;
			end
			if (have_aw_reg && have_w_reg && !o_s_axi_bvalid)
			begin
				have_aw_reg <= 1'b0;
				have_w_reg <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= `AXI_OKAY;
				case (aw_addr_reg)
					`ADDR_CTRL:
					begin
						if (wstrb_reg[0])
						begin
							ctrl_pwr_reg <= wdata_reg[`CTRL_PWR_BIT];
							ctrl_bl_reg <= wdata_reg[`CTRL_BL_BIT];
							timer_restart_reg <= wdata_reg[`CTRL_RESTART_BIT];
						end
					end
					`ADDR_DIM:
						if (wstrb_reg[0])
							full_level_reg <= clamp_level(wdata_reg);
					`ADDR_TIMEOUT:
						limit_reg <= {8'h00, merge(limit_reg[31:0], wdata_reg, wstrb_reg)};
					`ADDR_STATUS:
						o_s_axi_bresp <= `AXI_OKAY;
					default:
						o_s_axi_bresp <= `AXI_SLVERR;
				endcase
			end
			else if (o_s_axi_bvalid && i_s_axi_bready)
				o_s_axi_bvalid <= 1'b0;
		end
	end

	// axi4-lite read
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= `AXI_OKAY;
		end
		else if (o_s_axi_rvalid)
		begin
			if (i_s_axi_rready)
				o_s_axi_rvalid <= 1'b0;
		end
		else if (o_s_axi_arready && i_s_axi_arvalid)
		begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= `AXI_OKAY;
			case (i_s_axi_araddr)
				`ADDR_CTRL:
					o_s_axi_rdata <= {30'h0000_0000, ctrl_bl_reg, ctrl_pwr_reg};
				`ADDR_STATUS:
					o_s_axi_rdata <= {6'h00, o_dimmer_step, level_reg, dimmed_reg,
						voltage_mode_reg, bl_polarity_reg, edo_reg, panel_id_reg,
						state_reg};
				`ADDR_DIM:
					o_s_axi_rdata <= {25'h000_0000, full_level_reg};
				`ADDR_TIMEOUT:
					o_s_axi_rdata <= limit_reg[31:0];
				default:
				begin
					o_s_axi_rdata <= 32'h0000_0000;
					o_s_axi_rresp <= `AXI_SLVERR;
				end
			endcase
		end
		else
			o_s_axi_arready <= 1'b1;
	end
endmodule

/* display_power_backlight_ctrl_props.sv */
module dpb_checker (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [3:0] i_panel_id,
	input wire logic i_dram_type_strap,
	input wire logic i_backlight_polarity_strap,
	input wire logic i_key_press,
	input wire logic o_panel_supply_en,
	input wire logic o_panel_drive_en,
	input wire logic o_backlight_enable,
	input wire logic [6:0] o_dimmer_step,
	input wire logic o_dram_edo,
	input wire logic [3:0] o_panel_cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	supply_first_a: assert property ($rose(o_panel_drive_en) |-> $past(o_panel_supply_en, 2))
		else $error("drive rose without settled supply");
	drive_powered_a: assert property (o_panel_drive_en |-> o_panel_supply_en)
		else $error("drive on without supply");
	drain_first_a: assert property ($fell(o_panel_supply_en) |-> !$past(o_panel_drive_en, 2))
		else $error("supply removed too soon after drive");
	edo_capture_a: assert property (!$past(i_rst, 3) |->
		o_dram_edo == i_dram_type_strap && $stable(o_dram_edo))
		else $error("memory strap not held");
	panel_id_a: assert property (!$past(i_rst, 3) |->
		o_panel_cfg == i_panel_id && $stable(o_panel_cfg))
		else $error("panel id not held");
	bl_off_a: assert property (!$past(i_rst, 3) && !o_panel_drive_en && !$past(o_panel_drive_en)
		|-> o_backlight_enable == !i_backlight_polarity_strap)
		else $error("backlight not at off level");
	step_range_a: assert property (o_dimmer_step <= 7'h64)
		else $error("dimmer step beyond range");
	key_wake_a: assert property ($fell(i_key_press) |-> ##4 (o_dimmer_step != 7'h32) [*8])
		else $error("dimmed right after key");
endmodule
bind display_power_backlight_ctrl dpb_checker i_dpb_checker (.*);

/* display_power_backlight_ctrl_test.sv */
module display_power_backlight_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, key = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic rready = 0, edo = 0, pol = 0, ma = 0, mb = 0;
	logic [3:0] pid = 4'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, sup, drv, ble, dedo, fault, lamp;
	logic [6:0] step, bright;
	logic [3:0] cfg;
	logic [7:0] cfgs [3] = '{8'hF5, 8'h0A, 8'h43};
	int mismatches = 0, check_count = 0;
	always #12.5 clock = ~clock;
	display_power_backlight_ctrl #(.IDLE_LIMIT(40'h00_0000_0032), .SEQ_GAP(16'h0004))
	i_display_power_backlight_ctrl (.i_clock(clock), .i_rst(rst), .i_panel_id(pid),
		.i_dram_type_strap(edo), .i_backlight_polarity_strap(pol),
		.i_dimmer_mode_strap_a(ma), .i_dimmer_mode_strap_b(mb), .i_key_press(key),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_panel_supply_en(sup),
		.o_panel_drive_en(drv), .o_backlight_enable(ble), .o_dimmer_step(step),
		.o_dram_edo(dedo), .o_panel_cfg(cfg));
	lcd_panel_model i_lcd_panel_model (.i_clock(clock), .i_supply(sup), .i_drive(drv),
		.i_bl_enable(ble), .i_polarity(pol), .i_voltage_mode(ma & mb), .i_step(step),
		.o_fault(fault), .o_lamp_on(lamp), .o_brightness(bright));
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// every open-ended wait goes through here so a hang always ends the run
	task automatic tick(inout int n);
		@(posedge clock);
		n++;
		if (n > 200)
		begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			tick(n);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			tick(n);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic press;
		key <= 1'b1;
		@(posedge clock);
		key <= 1'b0;
		@(posedge clock);
	endtask
	task automatic t_reset(input logic [7:0] c);
		logic [31:0] d;
		logic [1:0] r;
		rst <= 1'b1;
		{mb, ma, pol, edo, pid} <= c;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		chk(dedo, c[4]);
		chk(cfg, c[3:0]);
		chk(ble, !c[5]);
		chk(bright, 7'h64);
		rd(8'h08, d, r);
		chk(d, 32'h0000_0064);
		wr(8'h10, 32'h0000_0001, r);
		chk(r, 2'h2);
		rd(8'h14, d, r);
		chk(r, 2'h2);
		chk(d, 32'h0000_0000);
		$display("reset test done");
	endtask
	task automatic t_power;
		int n;
		logic [1:0] r;
		wr(8'h00, 32'h0000_0003, r);
		n = 0;
		while (sup !== 1'b1)
			tick(n);
		n = 0;
		while (drv !== 1'b1)
			tick(n);
		chk(n >= 1, 1);
		repeat (3) @(posedge clock);
		chk(lamp, 1'b1);
		wr(8'h00, 32'h0000_0000, r);
		n = 0;
		while (drv !== 1'b0)
			tick(n);
		chk(sup, 1'b1);
		n = 0;
		while (sup !== 1'b0)
			tick(n);
		repeat (3) @(posedge clock);
		chk(lamp, 1'b0);
		chk(fault, 1'b0);
		$display("power test done");
	endtask
	task automatic t_dim(input logic vm);
		int n;
		logic [1:0] r;
		wr(8'h08, 32'h0000_0050, r);
		repeat (4) @(posedge clock);
		chk(step, vm ? 7'h14 : 7'h50);
		press();
		n = 0;
		while (bright !== 7'h32)
			tick(n);
		chk(n >= 48 && n <= 56, 1);
		chk(step, 7'h32);
		press();
		repeat (4) @(posedge clock);
		chk(bright, 7'h50);
		// a press midway must push dimming past the first deadline
		repeat (30) @(posedge clock);
		press();
		repeat (30) @(posedge clock);
		chk(bright, 7'h50);
		$display("dim test done");
	endtask
	task automatic t_limit;
		int n;
		logic [31:0] d;
		logic [1:0] r;
		// a shorter limit dims at once; the press below starts a clean interval
		wr(8'h0C, 32'h0000_0014, r);
		rd(8'h0C, d, r);
		chk(d, 32'h0000_0014);
		press();
		repeat (3) @(posedge clock);
		chk(bright, 7'h50);
		n = 0;
		while (bright !== 7'h32)
			tick(n);
		chk(n >= 16 && n <= 24, 1);
		rd(8'h04, d, r);
		chk(d[25:11], {7'h32, 7'h32, 1'b1});
		press();
		repeat (10) @(posedge clock);
		// restart strobe must push dimming past the deadline of the press
		wr(8'h00, 32'h0000_0004, r);
		repeat (10) @(posedge clock);
		chk(bright, 7'h50);
		$display("limit test done");
	endtask
	initial
	begin
		foreach (cfgs[i])
		begin
			t_reset(cfgs[i]);
			t_power();
			t_dim(cfgs[i][6] & cfgs[i][7]);
			t_limit();
		end
		conclude();
	end
endmodule

/* dpb_consts.vh */
`ifndef DPB_CONSTS_VH
`define DPB_CONSTS_VH
// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_DIM 8'h08
`define ADDR_TIMEOUT 8'h0C
// control fields
`define CTRL_PWR_BIT 0
`define CTRL_BL_BIT 1
`define CTRL_RESTART_BIT 2
// dimmer
`define DIM_STEPS 7'd100
`define DIM_FULL 7'd100
`define DIM_HALF 7'd50
// 10 minutes at 40 MHz = 24,000,000,000 cycles
`define IDLE_MINUTES 10
`define CLOCK_HZ 40000000
`define IDLE_CYCLES 40'h05_9682_F000
// sequencing delay between supply and drive, in cycles
`define SEQ_GAP_CYCLES 16'h0010
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

/* idle_timer.v */
`include "dpb_consts.vh"
// inactivity timer: restarts on key press, flags when it expires
module idle_timer #(
	parameter WIDTH = 40,
	parameter [39:0] LIMIT = `IDLE_CYCLES
) (
	input wire i_clock,
	input wire i_rst,
	input wire i_key,
	input wire [WIDTH-1:0] i_limit,
	output reg o_expired
);
	reg [WIDTH-1:0] count_reg;
	always @(posedge i_clock)
	begin
		if (i_rst || i_key)
		begin
			count_reg <= {WIDTH{1'b0}};
			o_expired <= 1'b0;
		end
		else if (count_reg >= i_limit - 1'b1)
			o_expired <= 1'b1;
		else
			count_reg <= count_reg + 1'b1;
	end
endmodule

/* lcd_panel_model.sv */
module lcd_panel_model (
	input wire logic i_clock,
	input wire logic i_supply,
	input wire logic i_drive,
	input wire logic i_bl_enable,
	input wire logic i_polarity,
	input wire logic i_voltage_mode,
	input wire logic [6:0] i_step,
	output logic o_fault,
	output logic o_lamp_on,
	output logic [6:0] o_brightness
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_fault = 1'b0;
	// drive into an unpowered panel damages it; latch so no glitch is missed
	always @(posedge i_clock)
		if (i_drive && !i_supply)
			o_fault <= 1'b1;
	assign o_lamp_on = (i_bl_enable == i_polarity);
	// wiper at zero is full light in voltage mode, dark in resistance mode
	assign o_brightness = i_voltage_mode ? 7'h64 - i_step : i_step;
endmodule
